// ---- logic/i2c_master_pkg.sv ----
package i2c_master_pkg;

	// Register byte offsets on the APB side
	localparam logic [4:0] OFS_DATA   = 5'h00;
	localparam logic [4:0] OFS_CTRL   = 5'h04;
	localparam logic [4:0] OFS_STATUS = 5'h08;
	localparam logic [4:0] OFS_RELOAD = 5'h0C;
	localparam logic [4:0] OFS_FLAGS  = 5'h10;

	// Second control register bit positions
	localparam int CTL_START   = 0;
	localparam int CTL_RSTART  = 1;
	localparam int CTL_RECV    = 3;
	localparam int CTL_ACKSEQ  = 4;
	localparam int CTL_ACKVAL  = 5;
	localparam int CTL_SLAVE_ACK_STATUS_BIT = 6;
	localparam int CTL_CMD_W   = 5;

	// Port status register bit positions
	localparam int STA_FULL  = 0;
	localparam int STA_START = 3;

	// Event flag register bit positions, write one to clear
	localparam int FLG_WRITE_COLLISION_FLAG = 0;
	localparam int FLG_OVF  = 1;
	localparam int FLG_PIF  = 2;
	localparam int FLG_BCL  = 3;

	// Widths, reset values and bit slot numbers
	localparam int          RELOAD_W     = 7;
	localparam int          RELOAD_RS_W  = 6;
	localparam logic [6:0]  RELOAD_RST   = 7'h00;
	localparam logic [3:0]  LAST_DATA    = 4'h7;
	localparam logic [3:0]  ACK_SLOT     = 4'h8;
	localparam logic [31:0] RDATA_RST    = 32'h0000_0000;

	// One bus sequence at a time
	typedef enum logic [3:0] {
		SQ_IDLE, SQ_ST_WAIT, SQ_ST_HOLD, SQ_RS_LOW, SQ_RS_RISE,
		SQ_RS_HIGH, SQ_RS_HOLD, SQ_TX_LOW, SQ_TX_HIGH, SQ_RX_LOW,
		SQ_RX_HIGH
	} seq_t;

	// Whole state of the master sequencer
	typedef struct packed {
		seq_t        seq;
		logic [6:0]  baud_counter;
		logic        run;
		logic [7:0]  shift;
		logic [3:0]  bits;
		logic [7:0]  buffer;
		logic [6:0]  reload;
		logic        start_enable_bit;
		logic        repeat_start_enable_bit;
		logic        receive_enable_bit;
		logic        ack_sequence_enable_bit;
		logic        ack_value_bit;
		logic        slave_ack_status_bit;
		logic        bf;
		logic        sdet;
		logic        write_collision_flag;
		logic        ovf;
		logic        pif;
		logic        bcl;
		logic        rx_mode;
		logic        scl_oe;
		logic        sda_oe;
		logic        scl_out;
		logic        sda_out;
		logic [1:0]  scl_sync;
		logic [1:0]  sda_sync;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} state_t;

endpackage : i2c_master_pkg

// ---- logic/i2c_master_sequencer.sv ----
// Register access over APB and the address map were decided locally.
`timescale 1ns/1ps
// Overview of operation
// - Baud reload value is the low seven bits of the reload register.
// - Baud counter decrements on each phase tick, stops at zero until reloaded.
// - Released SCL suspends counter until sampled high, then reloads and counts.
// - Start with both lines high reloads; at timeout drive SDA low, flag start.
// - After SDA low, reload; at timeout clear start bit, suspend counter.
// - Line low at start, or SCL low before SDA drop, is a collision.
// - Buffer write during start is dropped and sets write collision.
// - Low five command bits ignore writes until a start completes.
// - Repeat start from idle pulls SCL low, six-bit reload, releases SDA.
// - Repeat start needs both high one rollover, then SDA low one rollover.
// - Repeat start flags start at once, interrupt only after timeout.
// - Repeat start request is ignored while another event runs.
// - Repeat start collides on SDA low at SCL rise or early SCL fall.
// - Buffer write sets full flag, starts counter, shifts bits after SCL falls.
// - Eighth clock fall clears full flag and releases SDA for acknowledge.
// - Ninth clock fall samples SDA into the acknowledge status bit.
// - After ninth clock set interrupt, suspend counter, SCL low, SDA released.
// - Buffer write during transmit is dropped, sets write collision; software clears.
// - Receive enable is only accepted while the port is idle.
// - Receiving toggles SCL each rollover and shifts SDA into the shift register.
// - Eighth receive clock: clear enable, load buffer, set full and interrupt.
// - Reading the buffer after reception clears the full flag.
// - A byte completing while full flag is set raises receive overflow.
// - Buffer write during reception is dropped and sets write collision.
module i2c_master_sequencer
	import i2c_master_pkg::*;
#(
	parameter int ADDR_W = 5
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              ce,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              scl_in,
	output logic                   scl_out,
	output logic                   scl_oe,
	input  wire logic              sda_in,
	output logic                   sda_out,
	output logic                   sda_oe
);
	import i2c_master_pkg::*;

	// Elaboration check: the decoder needs the full five-bit offset
	if (ADDR_W < 5) begin : g_addr_check
		$error("ADDR_W must cover the register map");
	end

	state_t cur;
	state_t next_cur;

	logic       scl_s;
	logic       sda_s;
	logic       tmo;
	logic       acc;
	logic       wr;
	logic       rd;
	logic [4:0] ofs;
	logic       busy_start;

	// True while a Start or Repeated Start still runs
	function automatic logic in_start(input seq_t s);
		return s inside {SQ_ST_WAIT, SQ_ST_HOLD, SQ_RS_LOW, SQ_RS_RISE,
			SQ_RS_HIGH, SQ_RS_HOLD};
	endfunction : in_start

	// True while a byte is shifted in either direction
	function automatic logic in_byte(input seq_t s);
		return s inside {SQ_TX_LOW, SQ_TX_HIGH, SQ_RX_LOW, SQ_RX_HIGH};
	endfunction : in_byte

	////////////////////////////////////////////////////////////////////
	// Decoded views of the state
	assign scl_s      = cur.scl_sync[1];
	assign sda_s      = cur.sda_sync[1];
	assign tmo        = cur.run && (cur.baud_counter == '0);
	assign acc        = psel && penable && cur.pready;
	assign wr         = acc && pwrite;
	assign rd         = acc && !pwrite;
	assign ofs        = paddr[4:0];
	assign busy_start = in_start(cur.seq);

	assign prdata  = cur.prdata;
	assign pready  = cur.pready;
	assign pslverr = cur.pslverr;
	assign scl_out = cur.scl_out;
	assign scl_oe  = cur.scl_oe;
	assign sda_out = cur.sda_out;
	assign sda_oe  = cur.sda_oe;

	////////////////////////////////////////////////////////////////////
	// Next state: bus slave, command decode and bus sequencer
	always_comb begin
		next_cur = cur;
		// Pins cross into pclk here; only stage 1 is read by logic
		next_cur.scl_sync = {cur.scl_sync[0], scl_in};
		next_cur.sda_sync = {cur.sda_sync[0], sda_in};

		// APB answers one cycle into the access phase
		next_cur.pready  = psel && penable && !cur.pready;
		next_cur.pslverr = 1'b0;
		if (psel && penable && !cur.pready) begin
			next_cur.prdata = '0;
			unique case (ofs)
				OFS_DATA:   next_cur.prdata[7:0] = cur.buffer;
				OFS_CTRL: begin
					next_cur.prdata[CTL_START]   = cur.start_enable_bit;
					next_cur.prdata[CTL_RSTART]  = cur.repeat_start_enable_bit;
					next_cur.prdata[CTL_RECV]    = cur.receive_enable_bit;
					next_cur.prdata[CTL_ACKSEQ]  = cur.ack_sequence_enable_bit;
					next_cur.prdata[CTL_ACKVAL]  = cur.ack_value_bit;
					next_cur.prdata[CTL_SLAVE_ACK_STATUS_BIT] = cur.slave_ack_status_bit;
				end
				OFS_STATUS: begin
					next_cur.prdata[STA_FULL]  = cur.bf;
					next_cur.prdata[STA_START] = cur.sdet;
				end
				OFS_RELOAD: next_cur.prdata[6:0] = cur.reload;
				OFS_FLAGS: begin
					next_cur.prdata[FLG_WRITE_COLLISION_FLAG] = cur.write_collision_flag;
					next_cur.prdata[FLG_OVF]  = cur.ovf;
					next_cur.prdata[FLG_PIF]  = cur.pif;
					next_cur.prdata[FLG_BCL]  = cur.bcl;
				end
				default:    next_cur.pslverr = 1'b1;
			endcase
			if (paddr[ADDR_W-1:0] != ADDR_W'(ofs))
				next_cur.pslverr = 1'b1;
		end

		// Software clears of sticky flags; hardware sets below win
		if (wr && ofs == OFS_FLAGS) begin
			if (pwdata[FLG_WRITE_COLLISION_FLAG])
				next_cur.write_collision_flag = 1'b0;
			if (pwdata[FLG_OVF])
				next_cur.ovf = 1'b0;
			if (pwdata[FLG_PIF])
				next_cur.pif = 1'b0;
			if (pwdata[FLG_BCL])
				next_cur.bcl = 1'b0;
		end
		if (wr && ofs == OFS_RELOAD)
			next_cur.reload = pwdata[RELOAD_W-1:0];
		if (rd && ofs == OFS_DATA && cur.rx_mode)
			next_cur.bf = 1'b0;

		if (cur.run && cur.baud_counter != '0)
			next_cur.baud_counter = 7'(cur.baud_counter - 7'h01);

		// Acknowledge value bit is always writable; acknowledge sequence bit only outside a start
		if (wr && ofs == OFS_CTRL) begin
			next_cur.ack_value_bit = pwdata[CTL_ACKVAL];
			if (!busy_start) begin
				next_cur.ack_sequence_enable_bit = pwdata[CTL_ACKSEQ];
			end
		end

		unique case (cur.seq)
			SQ_IDLE: begin
				if (wr && ofs == OFS_CTRL && pwdata[CTL_START]) begin
					next_cur.start_enable_bit = 1'b1;
					if (scl_s && sda_s) begin
						next_cur.seq = SQ_ST_WAIT;
						next_cur.baud_counter = cur.reload;
						next_cur.run = 1'b1;
					end else begin
						next_cur.start_enable_bit = 1'b0;
						next_cur.bcl = 1'b1;
					end
				end else if (wr && ofs == OFS_CTRL &&
						pwdata[CTL_RSTART]) begin
					next_cur.repeat_start_enable_bit   = 1'b1;
					next_cur.seq    = SQ_RS_LOW;
					next_cur.scl_oe = 1'b1;
					next_cur.run    = 1'b0;
				end else if (wr && ofs == OFS_CTRL &&
						pwdata[CTL_RECV]) begin
					next_cur.receive_enable_bit    = 1'b1;
					next_cur.rx_mode = 1'b1;
					next_cur.seq     = SQ_RX_LOW;
					next_cur.bits    = '0;
					next_cur.scl_oe  = 1'b1;
					next_cur.baud_counter     = cur.reload;
					next_cur.run     = 1'b1;
				end else if (wr && ofs == OFS_DATA) begin
					next_cur.buffer  = pwdata[7:0];
					next_cur.shift   = pwdata[7:0];
					next_cur.bf      = 1'b1;
					next_cur.rx_mode = 1'b0;
					next_cur.bits    = '0;
					next_cur.seq     = SQ_TX_LOW;
					next_cur.scl_oe  = 1'b1;
					next_cur.baud_counter     = cur.reload;
					next_cur.run     = 1'b1;
				end
			end
			SQ_ST_WAIT: begin
				if (!scl_s) begin
					next_cur.bcl = 1'b1;
					next_cur.start_enable_bit = 1'b0;
					next_cur.run = 1'b0;
					next_cur.seq = SQ_IDLE;
				end else if (tmo) begin
					if (sda_s) begin
						next_cur.sda_oe = 1'b1;
						next_cur.sdet   = 1'b1;
						next_cur.baud_counter    = cur.reload;
						next_cur.seq    = SQ_ST_HOLD;
					end else begin
						next_cur.bcl = 1'b1;
						next_cur.start_enable_bit = 1'b0;
						next_cur.run = 1'b0;
						next_cur.seq = SQ_IDLE;
					end
				end
			end
			SQ_ST_HOLD: begin
				if (tmo) begin
					next_cur.start_enable_bit = 1'b0;
					next_cur.run = 1'b0;
					next_cur.pif = 1'b1;
					next_cur.seq = SQ_IDLE;
				end
			end
			SQ_RS_LOW: begin
				// six-bit reload once SCL is low
				if (!cur.run && !scl_s) begin
					next_cur.baud_counter    = {1'b0, cur.reload[RELOAD_RS_W-1:0]};
					next_cur.run    = 1'b1;
					next_cur.sda_oe = 1'b0;
				end else if (tmo) begin
					next_cur.run = 1'b0;
					if (sda_s) begin
						next_cur.scl_oe = 1'b0;
						next_cur.seq    = SQ_RS_RISE;
					end else begin
						next_cur.bcl    = 1'b1;
						next_cur.repeat_start_enable_bit   = 1'b0;
						next_cur.scl_oe = 1'b0;
						next_cur.seq    = SQ_IDLE;
					end
				end
			end
			SQ_RS_RISE: begin
				if (scl_s) begin
					if (!sda_s) begin
						next_cur.bcl  = 1'b1;
						next_cur.repeat_start_enable_bit = 1'b0;
						next_cur.seq  = SQ_IDLE;
					end else begin
						next_cur.baud_counter = cur.reload;
						next_cur.run = 1'b1;
						next_cur.seq = SQ_RS_HIGH;
					end
				end
			end
			SQ_RS_HIGH: begin
				if (!scl_s) begin
					next_cur.bcl  = 1'b1;
					next_cur.repeat_start_enable_bit = 1'b0;
					next_cur.run  = 1'b0;
					next_cur.seq  = SQ_IDLE;
				end else if (tmo) begin
					next_cur.sda_oe = 1'b1;
					next_cur.sdet   = 1'b1;
					next_cur.baud_counter    = cur.reload;
					next_cur.seq    = SQ_RS_HOLD;
				end
			end
			SQ_RS_HOLD: begin
				if (tmo) begin
					next_cur.repeat_start_enable_bit = 1'b0;
					next_cur.run  = 1'b0;
					next_cur.pif  = 1'b1;
					next_cur.seq  = SQ_IDLE;
				end
			end
			SQ_TX_LOW: begin
				// bit moves only once SCL is seen low
				// SDA in this state never changes while SCL may still be high
				if (!scl_s && cur.bits != ACK_SLOT)
					next_cur.sda_oe = !cur.shift[7];
				// SCL low one rollover, then release
				if (tmo) begin
					next_cur.scl_oe = 1'b0;
					next_cur.run    = 1'b0;
					next_cur.seq    = SQ_TX_HIGH;
				end
			end
			SQ_TX_HIGH: begin
				// wait for SCL high, then reload
				if (!cur.run) begin
					if (scl_s) begin
						next_cur.baud_counter = cur.reload;
						next_cur.run = 1'b1;
					end
				end else if (tmo) begin
					next_cur.scl_oe = 1'b1;
					if (cur.bits == ACK_SLOT) begin
						next_cur.slave_ack_status_bit = sda_s;
						next_cur.pif    = 1'b1;
						next_cur.run    = 1'b0;
						next_cur.sda_oe = 1'b0;
						next_cur.seq    = SQ_IDLE;
					end else begin
						next_cur.bits  = 4'(cur.bits + 4'h1);
						next_cur.shift = {cur.shift[6:0], 1'b0};
						next_cur.baud_counter   = cur.reload;
						next_cur.seq   = SQ_TX_LOW;
						if (cur.bits == LAST_DATA) begin
							next_cur.bf     = 1'b0;
							next_cur.sda_oe = 1'b0;
						end
					end
				end
			end
			SQ_RX_LOW: begin
				// Hand SDA to the slave only once SCL is seen low
				if (!scl_s)
					next_cur.sda_oe = 1'b0;
				if (tmo) begin
					next_cur.scl_oe = 1'b0;
					next_cur.run    = 1'b0;
					next_cur.seq    = SQ_RX_HIGH;
				end
			end
			SQ_RX_HIGH: begin
				if (!cur.run) begin
					if (scl_s) begin
						next_cur.baud_counter = cur.reload;
						next_cur.run = 1'b1;
					end
				end else if (tmo) begin
					// shift SDA in, SCL low again
					next_cur.shift  = {cur.shift[6:0], sda_s};
					next_cur.scl_oe = 1'b1;
					next_cur.bits   = 4'(cur.bits + 4'h1);
					if (cur.bits == LAST_DATA) begin
						next_cur.receive_enable_bit   = 1'b0;
						next_cur.buffer = {cur.shift[6:0], sda_s};
						next_cur.bf     = 1'b1;
						next_cur.pif    = 1'b1;
						next_cur.run    = 1'b0;
						next_cur.seq    = SQ_IDLE;
						if (cur.bf)
							next_cur.ovf = 1'b1;
					end else begin
						next_cur.baud_counter = cur.reload;
						next_cur.seq = SQ_RX_LOW;
					end
				end
			end
			default: next_cur.seq = SQ_IDLE;
		endcase

		// also while a byte shifts in
		if (wr && ofs == OFS_DATA && cur.seq != SQ_IDLE)
			next_cur.write_collision_flag = 1'b1;
	end

	////////////////////////////////////////////////////////////////////
	// State register, frozen while ce is low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cur        <= '0;
			cur.seq    <= SQ_IDLE;
			cur.reload <= RELOAD_RST;
			cur.prdata <= RDATA_RST;
			cur.scl_sync <= 2'h3;
			cur.sda_sync <= 2'h3;
		end else if (ce) begin
			cur <= next_cur;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Checks on the sequencer
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_write_collision_flag_busy_write: assert property (ce && wr && ofs == OFS_DATA &&
		in_byte(cur.seq) |=> cur.write_collision_flag && cur.buffer == $past(cur.buffer))
		else $error("buffer write during byte not refused");
	a_write_collision_flag_start: assert property (ce && wr && ofs == OFS_DATA &&
		busy_start |=> cur.write_collision_flag && !cur.bf)
		else $error("buffer write during start not refused");
	a_brg_step: assert property (ce && cur.run && cur.baud_counter != '0 &&
		!(cur.seq == SQ_IDLE && wr) |=> cur.baud_counter == 7'($past(cur.baud_counter) - 7'h01))
		else $error("baud counter did not decrement");
	a_start_drop: assert property (ce && cur.seq == SQ_ST_WAIT && tmo &&
		scl_s && sda_s |=> cur.sda_oe && cur.sdet &&
		cur.baud_counter == $past(cur.reload))
		else $error("start did not drive SDA low");
	a_start_done: assert property (ce && cur.seq == SQ_ST_HOLD && tmo |=>
		!cur.start_enable_bit && !cur.run && cur.sda_oe && cur.seq == SQ_IDLE)
		else $error("start did not complete");
	a_start_bcl: assert property (ce && cur.seq == SQ_ST_WAIT && !scl_s |=>
		cur.bcl && cur.seq == SQ_IDLE)
		else $error("start collision missed");
	a_brg_suspend: assert property (ce && cur.seq == SQ_TX_HIGH &&
		!cur.run && !scl_s |=> !cur.run && cur.seq == SQ_TX_HIGH)
		else $error("counter ran while SCL held low");
	a_ack_sample: assert property (ce && cur.seq == SQ_TX_HIGH && tmo &&
		cur.bits == ACK_SLOT |=> cur.slave_ack_status_bit == $past(sda_s) && cur.pif &&
		cur.scl_oe && !cur.sda_oe)
		else $error("ninth clock handling wrong");
	a_tx_release: assert property (ce && cur.seq == SQ_TX_HIGH && tmo &&
		cur.bits == LAST_DATA |=> !cur.bf && !cur.sda_oe ##0
		cur.seq == SQ_TX_LOW)
		else $error("eighth clock did not release SDA");
	a_rx_done: assert property (ce && cur.seq == SQ_RX_HIGH && tmo &&
		cur.bits == LAST_DATA |=> cur.bf && cur.pif && !cur.receive_enable_bit &&
		cur.scl_oe && cur.seq == SQ_IDLE)
		else $error("receive completion wrong");
	a_rx_overflow: assert property (ce && cur.seq == SQ_RX_HIGH && tmo &&
		cur.bits == LAST_DATA && cur.bf |=> cur.ovf)
		else $error("overflow not flagged");
	a_receive_enable_bit_ignored: assert property (ce && wr && ofs == OFS_CTRL &&
		cur.seq != SQ_IDLE |=> !cur.receive_enable_bit || $past(cur.receive_enable_bit))
		else $error("receive enable taken while busy");

	c_start:  cover property (cur.seq == SQ_ST_HOLD ##1 cur.seq == SQ_IDLE);
	c_rstart: cover property (cur.seq == SQ_RS_HOLD ##1 cur.seq == SQ_IDLE);
	c_tx_ack: cover property (cur.seq == SQ_TX_HIGH && tmo &&
		cur.bits == ACK_SLOT);
	c_rx_ovf: cover property (!cur.ovf ##1 cur.ovf);

endmodule : i2c_master_sequencer

// ---- verification/i2c_slave_model.sv ----
`timescale 1ns/1ps
module i2c_slave_model (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       scl,
	input  wire logic       sda,
	input  wire logic       ack_n,
	input  wire logic       tx_mode,
	input  wire logic [7:0] tx_byte,
	input  wire logic       stretch,
	output logic            scl_oe,
	output logic            sda_oe,
	output logic      [7:0] rx_byte
);
	logic       scl_q;
	logic       sda_q;
	logic       act;
	logic [3:0] cnt;
	logic [4:0] hold;
	logic [3:0] last;

	////////////////////////////////////////////////////////////////////////
	// Bit slots count on SCL falls; the fall after a start only arms
	assign last = tx_mode ? 4'h7 : 4'h8;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			act <= 1'b0;
			cnt <= 4'h0;
			hold <= 5'h00;
			rx_byte <= 8'h00;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
			if (hold != 5'h00)
				hold <= hold - 5'h01;
			if (scl && scl_q && sda_q && !sda) begin
				act <= 1'b0;
				cnt <= 4'h0;
			end else if (scl_q && !scl) begin
				act <= 1'b1;
				if (stretch)
					hold <= 5'h1F; // Longer than the master's low phase
				if (act)
					cnt <= (cnt == last) ? 4'h0 : cnt + 4'h1;
			end else if (!scl_q && scl && act && cnt < 4'h8)
				rx_byte <= {rx_byte[6:0], sda};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Slow slave holds SCL low; data changes only while SCL is low
	assign scl_oe = (hold != 5'h00);
	assign sda_oe = act && (tx_mode ? !tx_byte[3'h7 - cnt[2:0]]
		: (cnt == 4'h8 && !ack_n));
endmodule : i2c_slave_model

// ---- verification/tb_i2c_master_sequencer.sv ----
`timescale 1ns/1ps
module tb_i2c_master_sequencer;
	import i2c_master_pkg::*;
	localparam logic [31:0] W    = 32'h1 << FLG_WRITE_COLLISION_FLAG;
	localparam logic [31:0] O    = 32'h1 << FLG_OVF;
	localparam logic [31:0] P    = 32'h1 << FLG_PIF;
	localparam logic [31:0] B    = 32'h1 << FLG_BCL;
	localparam logic [31:0] FULL = 32'h1 << STA_FULL;
	localparam logic [31:0] SDET = 32'h1 << STA_START;
	localparam logic [31:0] ACKS = 32'h1 << CTL_SLAVE_ACK_STATUS_BIT;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [4:0]  paddr = 5'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        m_scl_oe;
	logic        m_sda_oe;
	logic        s_scl_oe;
	logic        s_sda_oe;
	logic        tb_scl_low = 1'b0;
	logic        ack_n = 1'b0;
	logic        tx_mode = 1'b0;
	logic        stretch = 1'b0;
	logic        ce = 1'b1;
	logic        m_scl_out;
	logic        m_sda_out;
	logic [7:0]  rx_byte;
	logic        scl;
	logic        sda;
	logic [31:0] q;
	logic        err;
	int          num_errors = 0;
	int          total_checks = 0;

	////////////////////////////////////////////////////////////////////////
	// Pulled-up open-drain lines, low while any party pulls
	assign scl = !(m_scl_oe || s_scl_oe || tb_scl_low);
	assign sda = !(m_sda_oe || s_sda_oe);
	always #20 pclk = ~pclk;

	i2c_master_sequencer dut_u (.pclk(pclk), .presetn(presetn), .ce(ce),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .scl_in(scl), .scl_out(m_scl_out),
		.scl_oe(m_scl_oe), .sda_in(sda), .sda_out(m_sda_out),
		.sda_oe(m_sda_oe));
	i2c_slave_model slave_u (.pclk(pclk), .presetn(presetn), .scl(scl),
		.sda(sda), .ack_n(ack_n), .tx_mode(tx_mode), .tx_byte(8'h96),
		.stretch(stretch), .scl_oe(s_scl_oe), .sda_oe(s_sda_oe),
		.rx_byte(rx_byte));

	////////////////////////////////////////////////////////////////////////
	task automatic summarize();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : summarize

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	// One APB transfer; request held until pready is seen at an edge
	task automatic apb(input logic w, input logic [4:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			num_errors++;
			summarize();
		end
		@(posedge pclk);
	endtask : apb

	task automatic rdc(input logic [4:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(q, exp);
	endtask : rdc

	// Bounded wait for one register bit to reach a level
	task automatic poll(input logic [4:0] a, input int b, input logic v);
		int n;
		n = 0;
		apb(1'b0, a, 32'h0);
		while (q[b] !== v && n < 400) begin
			apb(1'b0, a, 32'h0);
			n++;
		end
		if (q[b] !== v) begin
			num_errors++;
			summarize();
		end
	endtask : poll

	task automatic reset_dut();
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
	endtask : reset_dut

	////////////////////////////////////////////////////////////////////////
	initial begin
		reset_dut();
		for (int i = 1; i < 5; i++)
			rdc(5'(4 * i), 32'h0);
		apb(1'b0, 5'h14, 32'h0);
		check({31'h0, err}, 32'h1);
		apb(1'b1, OFS_RELOAD, 32'hFFFF_FFFF);
		rdc(OFS_RELOAD, 32'h7F);
		apb(1'b1, OFS_RELOAD, 32'h9);
		// Start, with a data write and a receive request refused while it runs
		apb(1'b1, OFS_CTRL, 32'h1);
		apb(1'b1, OFS_DATA, 32'h55);
		apb(1'b1, OFS_CTRL, 32'h9);
		poll(OFS_CTRL, CTL_START, 1'b0);
		rdc(OFS_CTRL, 32'h0);
		rdc(OFS_STATUS, SDET);
		rdc(OFS_FLAGS, W | P);
		rdc(OFS_DATA, 32'h0);
		check({30'h0, scl, sda}, 32'h2);
		// Transmit to a slave that stretches every low phase
		stretch <= 1'b1;
		apb(1'b1, OFS_FLAGS, 32'hF);
		apb(1'b1, OFS_DATA, 32'hA5);
		rdc(OFS_STATUS, FULL | SDET);
		apb(1'b1, OFS_DATA, 32'h11);
		apb(1'b1, OFS_CTRL, 32'hA);
		rdc(OFS_FLAGS, W);
		apb(1'b1, OFS_FLAGS, W);
		rdc(OFS_FLAGS, 32'h0);
		poll(OFS_FLAGS, FLG_PIF, 1'b1);
		check(32'(rx_byte), 32'hA5);
		rdc(OFS_CTRL, 32'h0);
		rdc(OFS_STATUS, SDET);
		check({30'h0, scl, sda}, 32'h1);
		// Second byte left unacknowledged
		stretch <= 1'b0;
		ack_n <= 1'b1;
		apb(1'b1, OFS_FLAGS, 32'hF);
		apb(1'b1, OFS_DATA, 32'hC3);
		// Frozen clock enable: SCL must stay low past one rollover
		ce <= 1'b0;
		repeat (16) @(posedge pclk);
		check({30'h0, scl, sda}, 32'h1);
		ce <= 1'b1;
		poll(OFS_FLAGS, FLG_PIF, 1'b1);
		check(32'(rx_byte), 32'hC3);
		rdc(OFS_CTRL, ACKS);
		// Two receptions; the buffer is not read in between
		tx_mode <= 1'b1;
		for (int i = 0; i < 2; i++) begin
			apb(1'b1, OFS_FLAGS, 32'hF);
			apb(1'b1, OFS_CTRL, 32'h8);
			apb(1'b1, OFS_DATA, 32'h77);
			poll(OFS_CTRL, CTL_RECV, 1'b0);
			rdc(OFS_FLAGS, (i == 1) ? (W | O | P) : (W | P));
			rdc(OFS_STATUS, FULL | SDET);
		end
		rdc(OFS_DATA, 32'h96);
		rdc(OFS_STATUS, SDET);
		// Software asks for the acknowledge sequence after the byte
		apb(1'b1, OFS_CTRL, 32'h1 << CTL_ACKSEQ);
		rdc(OFS_CTRL, ACKS | (32'h1 << CTL_ACKSEQ));
		tx_mode <= 1'b0;
		// Repeated start from idle after a second reset
		reset_dut();
		apb(1'b1, OFS_RELOAD, 32'h1F);
		apb(1'b1, OFS_CTRL, 32'h2);
		poll(OFS_STATUS, STA_START, 1'b1);
		rdc(OFS_FLAGS, 32'h0);
		poll(OFS_CTRL, CTL_RSTART, 1'b0);
		rdc(OFS_FLAGS, P);
		check({30'h0, scl, sda}, 32'h2);
		// Start refused while another party holds SCL low
		reset_dut();
		tb_scl_low <= 1'b1;
		apb(1'b1, OFS_CTRL, 32'h1);
		rdc(OFS_FLAGS, B);
		rdc(OFS_CTRL, 32'h0);
		tb_scl_low <= 1'b0;
		// Open-drain pins only ever drive a low level
		check({30'h0, m_scl_out, m_sda_out}, 32'h0);
		summarize();
	end
endmodule : tb_i2c_master_sequencer
